// *** hdl/rts_map.svh ***
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH

`define RTS_SLV_ADDR 7'h68
`define RTS_CLK_LAST 6'h07
`define RTS_LOC_CTRL 6'h08
`define RTS_HALT_BIT 7
`define RTS_ACK_BIT 4'h8
`define RTS_LAST_DBIT 4'h7
`define RTS_ARM_BIT 4'hF
`define RTS_HUND_DIV 9'h147
`define RTS_REC_CYCLES 32'd200000
`define RTS_CTRL_RST 8'h00
`define RTS_ONE 8'h01
`define RTS_ZERO 8'h00
`define RTS_MAX_99 8'h99
`define RTS_MAX_59 7'h59
`define RTS_MAX_HR 6'h23
`define RTS_MAX_DAY 3'h7
`define RTS_MAX_MON 8'h12
`define RTS_FEB 8'h02
`define RTS_APR 8'h04
`define RTS_JUN 8'h06
`define RTS_SEP 8'h09
`define RTS_NOV 8'h11
`define RTS_D28 8'h28
`define RTS_D29 8'h29
`define RTS_D30 8'h30
`define RTS_D31 8'h31
`define RTS_CENT_BIT 6

`endif

// *** hdl/rts_pkg.sv ***
package rts_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA
    } rts_state_t;
    typedef logic [7:0] rts_byte_t;
endpackage

// *** hdl/rts_slave.sv ***
// Function
// - answer only to START followed by slave address D0h
// - 64 byte locations: clock, control, watchdog, alarms, square wave, RAM
// - byte pointer advances after every data byte written, or read and acknowledged
// - eight locations hold clock/calendar values in BCD
// - hundredths, seconds, minutes, 24-hour hours with century bit, day, date, month, year
// - month lengths 28/29/30/31 adjusted, leap rule valid until 2100
// - ninth location holds clock access control and calibration setting
// - twelve further locations for alarm, watchdog, square-wave control
// - timekeeping runs from the 32.768 kHz oscillator
// - power fail aborts any access and clears the pointer
// - during power fail all bus inputs are ignored
// - writes stay blocked for a recovery time after power returns
// - data changes while clock high are control conditions
// - data falling while clock high is START
// - data rising while clock high is STOP, ending the transfer
// - one bit per clock pulse, sampled while clock high
// - unlimited bytes between START and STOP
// - ninth bit acknowledges, driven low by the receiver
// - every received byte is acknowledged, unless the slave address does not match
// - acknowledge held low over the whole acknowledge high phase
// - no master acknowledge ends a read; device releases data line
// - random read: word address write, repeated START, then read
// - on reads pointer advances only after master acknowledge
// - clock copy frozen while reading 00h-07h, until master withholds acknowledge, STOP, or pointer leaves 00h-07h
// - read without word address starts at current pointer
`timescale 1ns/1ps
`default_nettype none
`include "rts_map.svh"
module rts_slave
    import rts_pkg::*;
#(
    parameter logic [31:0] REC_CYCLES = `RTS_REC_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_osc,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic power_fail_in,
    output logic write_protect
);

    function automatic rts_byte_t bcd_inc(input rts_byte_t v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // oscillator domain: hundredths tick as a toggle
    // limitation: 328-cycle divide runs about 0.1% slow without trim
    logic [8:0] div_q;
    logic tog_q;
    always_ff @(posedge clk_osc or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 9'h000;
            tog_q <= 1'b0;
        end else if (div_q == `RTS_HUND_DIV) begin
            div_q <= 9'h000;
            tog_q <= ~tog_q;
        end else begin
            div_q <= div_q + 9'h001;
        end
    end

    // synchronisers: pins and the tick toggle
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic pf_m_q, pf_s_q;
    logic tk_m_q, tk_s_q, tk_p_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            {pf_m_q, pf_s_q} <= 2'h0;
            {tk_m_q, tk_s_q, tk_p_q} <= 3'h0;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
            {pf_m_q, pf_s_q} <= {power_fail_in, pf_m_q};
            {tk_m_q, tk_s_q, tk_p_q} <= {tog_q, tk_m_q, tk_s_q};
        end
    end

    wire tick = tk_s_q ^ tk_p_q;
    wire pf = pf_s_q;
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // recovery hold after power returns
    logic [31:0] rec_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rec_q <= 32'h0;
        end else if (pf) begin
            rec_q <= REC_CYCLES;
        end else if (rec_q != 32'h0) begin
            rec_q <= rec_q - 32'h1;
        end
    end
    wire wp = pf | (rec_q != 32'h0);
    assign write_protect = wp;

    // serial engine state
    rts_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    rts_byte_t sh_q, sh_d, tx_q, tx_d;
    logic [5:0] ptr_q, ptr_d;
    logic oe_q, oe_d;
    logic wr_en;
    rts_byte_t rd_byte;

    // timekeeping counters and the user-visible copy
    rts_byte_t tk_q [0:7];
    rts_byte_t tk_d [0:7];
    rts_byte_t snap_q [0:7];
    rts_byte_t ctrl_q;
    rts_byte_t mem [0:63];
    logic frz_q;

    wire is_clk = ptr_q <= `RTS_CLK_LAST;
    wire is_ctrl = ptr_q == `RTS_LOC_CTRL;
    wire wr_ok = wr_en & ~wp;
    // halt bit of the control location
    wire halt = ctrl_q[`RTS_HALT_BIT];
    assign rd_byte = is_clk ? snap_q[ptr_q[2:0]] :
                     is_ctrl ? ctrl_q : mem[ptr_q];

    wire rts_byte_t mon = tk_q[6];
    wire rts_byte_t yr = tk_q[7];
    // year 00 counts as leap, right through 2099
    wire leap = yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00);
    wire m30 = (mon == `RTS_APR) | (mon == `RTS_JUN) |
               (mon == `RTS_SEP) | (mon == `RTS_NOV);
    wire rts_byte_t mdays = (mon == `RTS_FEB) ?
                            (leap ? `RTS_D29 : `RTS_D28) :
                            (m30 ? `RTS_D30 : `RTS_D31);
    wire rts_byte_t hr_inc = bcd_inc(tk_q[3]);

    // BCD ripple of the clock fields
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            tk_d[i] = tk_q[i];
        end
        if (tick && !halt) begin
            if (tk_q[0] != `RTS_MAX_99) begin
                tk_d[0] = bcd_inc(tk_q[0]);
            end else begin
                tk_d[0] = `RTS_ZERO;
                if (tk_q[1][6:0] != `RTS_MAX_59) begin
                    tk_d[1] = bcd_inc(tk_q[1]);
                end else begin
                    tk_d[1] = `RTS_ZERO;
                    if (tk_q[2][6:0] != `RTS_MAX_59) begin
                        tk_d[2] = bcd_inc(tk_q[2]);
                    end else begin
                        tk_d[2] = `RTS_ZERO;
                        if (tk_q[3][5:0] != `RTS_MAX_HR) begin
                            tk_d[3][5:0] = hr_inc[5:0];
                        end else begin
                            tk_d[3][5:0] = 6'h00;
                            tk_d[4] = (tk_q[4][2:0] == `RTS_MAX_DAY) ?
                                      `RTS_ONE : bcd_inc(tk_q[4]);
                            if (tk_q[5] != mdays) begin
                                tk_d[5] = bcd_inc(tk_q[5]);
                            end else begin
                                tk_d[5] = `RTS_ONE;
                                if (mon != `RTS_MAX_MON) begin
                                    tk_d[6] = bcd_inc(mon);
                                end else begin
                                    tk_d[6] = `RTS_ONE;
                                    if (yr != `RTS_MAX_99) begin
                                        tk_d[7] = bcd_inc(yr);
                                    end else begin
                                        tk_d[7] = `RTS_ZERO;
                                        tk_d[3][`RTS_CENT_BIT] =
                                            ~tk_q[3][`RTS_CENT_BIT];
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
        // bus write wins over a tick in the same cycle
        if (wr_ok && is_clk) begin
            tk_d[ptr_q[2:0]] = sh_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                tk_q[i] <= `RTS_ZERO;
            end
            tk_q[4] <= `RTS_ONE;
            tk_q[5] <= `RTS_ONE;
            tk_q[6] <= `RTS_ONE;
        end else begin
            tk_q <= tk_d;
        end
    end

    wire frz_d = (st_q == ST_RDATA && is_clk) ? 1'b1 :
                 (stop_c || !is_clk || st_q == ST_IDLE) ? 1'b0 : frz_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            frz_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                snap_q[i] <= `RTS_ZERO;
            end
        end else begin
            frz_q <= frz_d;
            if (!frz_d) begin
                snap_q <= tk_d;
            end
        end
    end

    // control byte, calibration kept in low bits
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `RTS_CTRL_RST;
        end else if (wr_ok && is_ctrl) begin
            ctrl_q <= sh_q;
        end
    end

    // alarm, watchdog, square wave and user RAM bytes
    // battery-backed array: no reset, contents survive rst_b
    always_ff @(posedge clk_sys) begin
        if (wr_ok && !is_clk && !is_ctrl) begin
            mem[ptr_q] <= sh_q;
        end
    end

    // serial engine next state
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        tx_d = tx_q;
        wr_en = 1'b0;
        if (pf) begin
            st_d = ST_IDLE;
            ptr_d = 6'h00;
            oe_d = 1'b0;
            bit_d = 4'h0;
        end else if (start_c) begin
            st_d = ST_DEV;
            bit_d = `RTS_ARM_BIT;
            oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (st_q != ST_IDLE) begin
            if (scl_rise) begin
                if (bit_q != `RTS_ACK_BIT) begin
                    sh_d = {sh_q[6:0], sda_s_q};
                end else if (st_q == ST_RDATA) begin
                    if (!sda_s_q) begin
                        ptr_d = ptr_q + 6'h01;
                    // no acknowledge: let go and wait
                    end else begin
                        st_d = ST_IDLE;
                    end
                end
            end else if (scl_fall) begin
                if (bit_q == `RTS_ARM_BIT) begin
                    // fall closing the start is not a data bit
                    bit_d = 4'h0;
                end else if (bit_q < `RTS_LAST_DBIT) begin
                    bit_d = bit_q + 4'h1;
                    // drive next bit only after clock is low
                    if (st_q == ST_RDATA) begin
                        tx_d = {tx_q[6:0], 1'b1};
                        oe_d = ~tx_q[6];
                    end
                end else if (bit_q == `RTS_LAST_DBIT) begin
                    bit_d = `RTS_ACK_BIT;
                    // receiver pulls the ninth bit low
                    oe_d = (st_q != ST_RDATA);
                    case (st_q)
                        ST_DEV: begin
                            if (sh_q[7:1] != `RTS_SLV_ADDR) begin
                                st_d = ST_IDLE;
                                oe_d = 1'b0;
                            end
                        end
                        ST_WORD: ptr_d = sh_q[5:0];
                        ST_WDATA: begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 6'h01;
                        end
                        default: ;
                    endcase
                end else begin
                    bit_d = 4'h0;
                    oe_d = 1'b0;
                    case (st_q)
                        ST_DEV: begin
                            if (sh_q[0]) begin
                                st_d = ST_RDATA;
                                tx_d = rd_byte;
                                oe_d = ~rd_byte[7];
                            end else begin
                                st_d = ST_WORD;
                            end
                        end
                        ST_WORD: st_d = ST_WDATA;
                        ST_RDATA: begin
                            tx_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= `RTS_ZERO;
            tx_q <= `RTS_ZERO;
            ptr_q <= 6'h00;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;

endmodule
`default_nettype wire

// *** verification/rts_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module rts_i2c_master (
    input wire logic sda_in,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data moves only with clock low
    task automatic put_bit(input logic b, output logic seen);
        sda_drv = b;
        #100;
        scl = 1'b1;
        #200;
        seen = sda_in;
        scl = 1'b0;
        #100;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        #100;
        scl = 1'b1;
        #100;
        sda_drv = 1'b0;
        #100;
        scl = 1'b0;
        #100;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #100;
        scl = 1'b1;
        #100;
        sda_drv = 1'b1;
        #100;
    endtask
    task automatic release_bus();
        sda_drv = 1'b1;
        #100;
        scl = 1'b1;
        #100;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = !s;
    endtask
    // ack held low, withheld on last byte
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(!ack, s);
    endtask
endmodule
`default_nettype wire

// *** verification/rts_slave_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module rts_slave_asserts #(
    parameter logic [31:0] REC_CYCLES = 32'd200000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_osc,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic power_fail_in,
    input wire logic write_protect
);
    logic [31:0] wp_cnt_q;
    logic [31:0] wp_cnt_d;
    // counts protection cycles elapsed since power returned
    assign wp_cnt_d = (write_protect && !power_fail_in) ?
        wp_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wp_cnt_q <= 32'h0;
        end else begin
            wp_cnt_q <= wp_cnt_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_o)
        else $error("data pin driven high");
    AST_PF_QUIET: assert property (power_fail_in [*6] |-> !sda_oe)
        else $error("data pin driven during power fail");
    AST_PF_RISE: assert property (
        $rose(power_fail_in) |-> ##[1:4] write_protect)
        else $error("no write protect on power fail");
    AST_WP_HOLD: assert property (
        $fell(power_fail_in) |-> write_protect [*8])
        else $error("write protect dropped early");
    AST_WP_BOUND: assert property (wp_cnt_q <= REC_CYCLES + 32'd8)
        else $error("write protect held too long");
    AST_OE_TIMING: assert property (
        $changed(sda_oe) && !write_protect |->
        !scl_i && !$past(scl_i, 2) && $past(scl_i, 6))
        else $error("data pin changed away from clock fall");
    AST_ACK_STABLE: assert property (
        scl_i && sda_oe |=> sda_oe || !scl_i)
        else $error("data pin released while clock high");
    AST_RESET_IDLE: assert property (
        disable iff (1'b0) !rst_b |-> !sda_oe && !write_protect)
        else $error("outputs active in reset");
endmodule
bind rts_slave rts_slave_asserts #(.REC_CYCLES(REC_CYCLES)) u_asserts (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_osc(clk_osc),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .power_fail_in(power_fail_in),
    .write_protect(write_protect)
);
`default_nettype wire

// *** verification/test_rts_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_rts_slave;
    import rts_pkg::*;
    // long enough to fit a read and a write while protected
    localparam logic [31:0] REC = 32'd8000;
    logic clk_sys = 1'b0;
    logic clk_osc = 1'b0;
    logic rst_b = 1'b1;
    logic power_fail_in = 1'b0;
    logic scl, sda_drv, sda, sda_o, sda_oe, write_protect;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    assign sda = sda_drv & ~(sda_oe & ~sda_o);
    always #2.5 clk_sys = ~clk_sys;
    always #40 clk_osc = ~clk_osc;
    rts_i2c_master u_master (.sda_in(sda), .scl(scl), .sda_drv(sda_drv));
    rts_slave #(.REC_CYCLES(REC)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_osc(clk_osc),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .power_fail_in(power_fail_in), .write_protect(write_protect)
    );
    task automatic end_sim();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            end_sim();
        end
    end
    task automatic check(input string what, input rts_byte_t seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input rts_byte_t d, input logic exp_ack);
        logic a;
        u_master.wbyte(d, a);
        check("ack", {7'h00, a}, {7'h00, exp_ack});
    endtask
    task automatic wr_at(input rts_byte_t p, d0, d1);
        u_master.start();
        send(8'hD0, 1'b1);
        send(p, 1'b1);
        send(d0, 1'b1);
        send(d1, 1'b1);
        u_master.stop();
    endtask
    task automatic rd_at(input rts_byte_t p, e0, e1);
        rts_byte_t d;
        u_master.start();
        send(8'hD0, 1'b1);
        send(p, 1'b1);
        u_master.start();
        send(8'hD1, 1'b1);
        u_master.rbyte(1'b1, d);
        check("first read", d, e0);
        u_master.rbyte(1'b0, d);
        check("second read", d, e1);
        u_master.stop();
    endtask
    task automatic rd_cur(input rts_byte_t e0);
        rts_byte_t d;
        u_master.start();
        send(8'hD1, 1'b1);
        u_master.rbyte(1'b0, d);
        check("current read", d, e0);
        u_master.stop();
    endtask
    task automatic t_basic();
        // halt bit set so clock fields stay put
        wr_at(8'h08, 8'h80, 8'hAA);
        rd_at(8'h08, 8'h80, 8'hAA);
        rd_cur(8'hAA);
    endtask
    task automatic t_wrong_addr();
        u_master.start();
        send(8'hA0, 1'b0);
        u_master.stop();
        rd_cur(8'hAA);
    endtask
    task automatic t_wrap();
        wr_at(8'h3F, 8'h5A, 8'h77);
        rd_at(8'h3F, 8'h5A, 8'h77);
    endtask
    task automatic t_power_fail();
        logic s;
        wr_at(8'h10, 8'h5A, 8'hC3);
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h10, 1'b1);
        repeat (3) u_master.put_bit(1'b1, s);
        @(posedge clk_sys) #1 power_fail_in = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        check("protect", {7'h00, write_protect}, 8'h01);
        check("drive", {7'h00, sda_oe}, 8'h00);
        u_master.release_bus();
        u_master.start();
        send(8'hD0, 1'b0);
        u_master.stop();
        @(posedge clk_sys) #1 power_fail_in = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        rd_cur(8'h77);
        check("protect", {7'h00, write_protect}, 8'h01);
        wr_at(8'h10, 8'h33, 8'h44);
        check("protect", {7'h00, write_protect}, 8'h01);
        for (int i = 0; i < 9000 && write_protect !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check("protect", {7'h00, write_protect}, 8'h00);
        rd_at(8'h10, 8'h5A, 8'hC3);
        wr_at(8'h10, 8'h33, 8'h44);
        rd_at(8'h10, 8'h33, 8'h44);
    endtask
    task automatic t_rollover();
        rts_byte_t d;
        rts_byte_t wv [0:8] = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07,
                                8'h28, 8'h02, 8'h00, 8'h00};
        rts_byte_t ev [1:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29,
                                8'h02, 8'h00};
        // last byte clears halt; year 00 is a leap year
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h00, 1'b1);
        foreach (wv[i]) send(wv[i], 1'b1);
        u_master.stop();
        // one hundredth tick or two, seconds stay put for long after
        repeat (6000) @(posedge clk_sys);
        #1;
        u_master.start();
        send(8'hD0, 1'b1);
        send(8'h01, 1'b1);
        u_master.start();
        send(8'hD1, 1'b1);
        for (int i = 1; i <= 7; i++) begin
            u_master.rbyte(i < 7, d);
            check("calendar", d, ev[i]);
        end
        u_master.stop();
    endtask
    initial begin
        #1 rst_b = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        t_basic();
        t_wrong_addr();
        t_wrap();
        t_power_fail();
        t_rollover();
        end_sim();
    end
endmodule
`default_nettype wire
